// *** verilog/afc_pkg.sv ***
// Package: register map, field layout, reset values and codes of the format control bank
//
// How it works
// - A two-bit de-emphasis rate field picks 44.1 kHz (00, reset), 48 kHz (01) or 32 kHz (10), 11 reserved, used only while de-emphasis is on.
// - Audio format codes 000 to 011 pick right-justified input with 24, 20, 18 and 16 bit words.
// - Audio format code 100 picks I2S, 101 (reset) picks left-justified, 110 and 111 are reserved.
// - Bit 5 of the format register picks sharp rolloff when clear (reset) and slow rolloff when set.
// - The attenuation mode bit picks 0.5 dB steps to -63 dB when clear (reset) and 1 dB steps to -100 dB when set.
// - Bit 0 of the phase register leaves output polarity normal when clear (reset) and inverts it when set.
// - Bit 1 makes zero flags high on zero detect when clear (reset) and low when set.
// - Bit 2 gives separate left and right zero flags when clear (reset) and one combined flag with the other unassigned when set.
// - Each attenuator moves one step of the chosen size toward its target every eight sample periods.
// - The de-emphasis enable bit turns de-emphasis off when clear (reset) and on when set.
package afc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_DEEMPH = 7'h13;
  localparam logic [6:0] IDX_FORMAT = 7'h14;
  localparam logic [6:0] IDX_ATTMODE = 7'h15;
  localparam logic [6:0] IDX_PHASE = 7'h16;
  localparam logic [6:0] IDX_ATTL = 7'h30;
  localparam logic [6:0] IDX_ATTR = 7'h31;
  localparam logic [6:0] IDX_ZERO_IN = 7'h32;
  localparam logic [6:0] IDX_STATUS = 7'h33;
  // Control word layout
  localparam int CW_TOP = 15;
  localparam int CW_IDX_HI = 14;
  localparam int CW_IDX_LO = 8;
  // Field positions
  localparam int DEEMPH_EN_BIT = 4;
  localparam int DEEMPH_RATE_LO = 5;
  localparam int FMT_LO = 0;
  localparam int ROLLOFF_BIT = 5;
  localparam int ATT_MODE_BIT = 0;
  localparam int PHASE_BIT = 0;
  localparam int ZPOL_BIT = 1;
  localparam int ZCOMB_BIT = 2;
  // Reset values
  localparam logic [1:0] DEEMPH_RATE_RST = 2'h0;
  localparam logic [2:0] FMT_RST = 3'h5;
  localparam logic [7:0] ATT_RST = 8'hFF;
  // Rate codes
  localparam logic [1:0] RATE_44K1 = 2'h0;
  localparam logic [1:0] RATE_48K = 2'h1;
  localparam logic [1:0] RATE_32K = 2'h2;
  // Format codes
  localparam logic [2:0] FMT_RJ24 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ18 = 3'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h3;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LJ = 3'h5;
  // Attenuator floors: below these codes is mute
  localparam logic [7:0] ATT_FLOOR_FINE = 8'h81;
  localparam logic [7:0] ATT_FLOOR_WIDE = 8'h9B;
  // Sample periods per attenuator move of one code
  localparam int SAMPLES_PER_STEP = 8;
  // Default sample period in reference clocks (40 MHz / 48 kHz, rounded down)
  localparam int CLK_HZ = 40000000;
  localparam int FS_HZ = 48000;
  localparam int CLKS_PER_SAMPLE = CLK_HZ / FS_HZ;
  // Serial frame format selections
  typedef enum logic [1:0] {AFC_FRAME_RJ = 2'h0, AFC_FRAME_I2S = 2'h1, AFC_FRAME_LJ = 2'h3,
    AFC_FRAME_BAD = 2'h2} afc_frame_t;
endpackage

// *** verilog/afc_regs.sv ***
// Format control register bank with Avalon-MM slave and attenuator stepping
//
// Chosen here: the Avalon-MM slave port.
module afc_regs #(
  parameter int CLKS_PER_SAMPLE = afc_pkg::CLKS_PER_SAMPLE
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic zero_left_i,
  input wire logic zero_right_i,
  output logic deemph_enable_o,
  output logic [1:0] deemph_rate_sel_o,
  output logic [1:0] serial_frame_o,
  output logic [4:0] word_bits_o,
  output logic filter_rolloff_sel_o,
  output logic atten_step_mode_o,
  output logic output_phase_invert_o,
  output logic [7:0] atten_left_o,
  output logic [7:0] atten_right_o,
  output logic left_zero_flag_o,
  output logic right_zero_flag_o
);
  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  initial begin
    if (CLKS_PER_SAMPLE < 1)
      $error("CLKS_PER_SAMPLE must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [6:0] idx;
  logic wr_ok;
  logic rd_busy_r;
  logic [7:0] wdata;
  logic [15:0] cword;
  logic deemph_rate_ok;
  logic fmt_ok;
  logic deemph_en_r;
  logic [1:0] deemph_rate_r;
  logic [2:0] fmt_r;
  logic rolloff_r;
  logic att_mode_r;
  logic phase_r;
  logic zpol_r;
  logic zcomb_r;
  logic [7:0] att_tgt_l_r;
  logic [7:0] att_tgt_r_r;
  logic [7:0] att_cur_l_r;
  logic [7:0] att_cur_r_r;
  logic [$clog2(CLKS_PER_SAMPLE+1)-1:0] smp_cnt_r;
  logic [2:0] step_cnt_r;
  logic step_en;
  logic zl_s1_r;
  logic zl_s2_r;
  logic zr_s1_r;
  logic zr_s2_r;

  assign cword = avs_writedata_i[15:0];
  assign wr_ok = avs_write_i && avs_byteenable_i[0] && !cword[afc_pkg::CW_TOP];
  assign wdata = cword[7:0];
  assign deemph_rate_ok = wdata[afc_pkg::DEEMPH_RATE_LO +: 2] != 2'h3;
  assign fmt_ok = wdata[afc_pkg::FMT_LO +: 3] < 3'h6;

  // Register index from byte address
  function automatic logic [6:0] word_idx(input logic [7:0] a);
    word_idx = {1'h0, a[7:2]};
  endfunction

  assign idx = word_idx(avs_address_i);

  // Reads take one extra cycle: waitrequest drops on the second
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rd_busy_r <= 1'h0;
    else
      rd_busy_r <= avs_read_i && !rd_busy_r;
  end

  assign avs_waitrequest_o = avs_read_i && !rd_busy_r;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      deemph_en_r <= 1'h0;
      deemph_rate_r <= afc_pkg::DEEMPH_RATE_RST;
      fmt_r <= afc_pkg::FMT_RST;
      rolloff_r <= 1'h0;
      att_mode_r <= 1'h0;
      phase_r <= 1'h0;
      zpol_r <= 1'h0;
      zcomb_r <= 1'h0;
      att_tgt_l_r <= afc_pkg::ATT_RST;
      att_tgt_r_r <= afc_pkg::ATT_RST;
    end
    else if (wr_ok)
    begin
      case (idx)
        afc_pkg::IDX_DEEMPH:
        begin
          deemph_en_r <= wdata[afc_pkg::DEEMPH_EN_BIT];
          if (deemph_rate_ok)
            deemph_rate_r <= wdata[afc_pkg::DEEMPH_RATE_LO +: 2];
        end
        afc_pkg::IDX_FORMAT:
        begin
          if (fmt_ok)
            fmt_r <= wdata[afc_pkg::FMT_LO +: 3];
          rolloff_r <= wdata[afc_pkg::ROLLOFF_BIT];
        end
        afc_pkg::IDX_ATTMODE: att_mode_r <= wdata[afc_pkg::ATT_MODE_BIT];
        afc_pkg::IDX_PHASE:
        begin
          phase_r <= wdata[afc_pkg::PHASE_BIT];
          zpol_r <= wdata[afc_pkg::ZPOL_BIT];
          zcomb_r <= wdata[afc_pkg::ZCOMB_BIT];
        end
        afc_pkg::IDX_ATTL: att_tgt_l_r <= wdata;
        afc_pkg::IDX_ATTR: att_tgt_r_r <= wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Step timer: one pulse every eight sample periods
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      smp_cnt_r <= '0;
      step_cnt_r <= 3'h0;
    end
    else if (smp_cnt_r == ($bits(smp_cnt_r))'(CLKS_PER_SAMPLE - 1))
    begin
      smp_cnt_r <= '0;
      step_cnt_r <= step_cnt_r + 3'h1;
    end
    else
      smp_cnt_r <= smp_cnt_r + 1'b1;
  end

  assign step_en = (smp_cnt_r == ($bits(smp_cnt_r))'(CLKS_PER_SAMPLE - 1)) && (step_cnt_r == 3'h7);

  // Next attenuator code one step toward target, mute below mode floor
  function automatic logic [7:0] att_step(input logic [7:0] cur, input logic [7:0] tgt,
                                          input logic wide);
    logic [7:0] floor_v;
    logic [7:0] t;
    floor_v = wide ? afc_pkg::ATT_FLOOR_WIDE : afc_pkg::ATT_FLOOR_FINE;
    t = (tgt < floor_v) ? 8'h00 : tgt;
    if (cur == t)
      att_step = cur;
    else if (cur < t)
      att_step = (cur < floor_v) ? floor_v : cur + 8'h01;
    else
      att_step = (cur <= floor_v) ? 8'h00 : cur - 8'h01;
  endfunction

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      att_cur_l_r <= afc_pkg::ATT_RST;
      att_cur_r_r <= afc_pkg::ATT_RST;
    end
    else if (step_en)
    begin
      att_cur_l_r <= att_step(att_cur_l_r, att_tgt_l_r, att_mode_r);
      att_cur_r_r <= att_step(att_cur_r_r, att_tgt_r_r, att_mode_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero detect inputs synchronised
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      zl_s1_r <= 1'h0;
      zl_s2_r <= 1'h0;
      zr_s1_r <= 1'h0;
      zr_s2_r <= 1'h0;
    end
    else
    begin
      zl_s1_r <= zero_left_i;
      zl_s2_r <= zl_s1_r;
      zr_s1_r <= zero_right_i;
      zr_s2_r <= zr_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      left_zero_flag_o <= 1'h0;
      right_zero_flag_o <= 1'h0;
      deemph_enable_o <= 1'h0;
      deemph_rate_sel_o <= afc_pkg::DEEMPH_RATE_RST;
      serial_frame_o <= afc_pkg::AFC_FRAME_LJ;
      word_bits_o <= 5'h18;
      filter_rolloff_sel_o <= 1'h0;
      atten_step_mode_o <= 1'h0;
      output_phase_invert_o <= 1'h0;
      atten_left_o <= afc_pkg::ATT_RST;
      atten_right_o <= afc_pkg::ATT_RST;
    end
    else
    begin
      // separate or combined flags; unassigned pin held inactive
      if (zcomb_r)
      begin
        left_zero_flag_o <= zpol_r;
        right_zero_flag_o <= (zl_s2_r & zr_s2_r) ^ zpol_r;
      end
      else
      begin
        left_zero_flag_o <= zl_s2_r ^ zpol_r;
        right_zero_flag_o <= zr_s2_r ^ zpol_r;
      end
      deemph_enable_o <= deemph_en_r;
      deemph_rate_sel_o <= deemph_en_r ? deemph_rate_r : afc_pkg::RATE_44K1;
      case (fmt_r)
        afc_pkg::FMT_RJ24: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_RJ, 5'h18};
        afc_pkg::FMT_RJ20: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_RJ, 5'h14};
        afc_pkg::FMT_RJ18: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_RJ, 5'h12};
        afc_pkg::FMT_RJ16: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_RJ, 5'h10};
        afc_pkg::FMT_I2S: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_I2S, 5'h18};
        afc_pkg::FMT_LJ: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_LJ, 5'h18};
        default: {serial_frame_o, word_bits_o} <= {afc_pkg::AFC_FRAME_BAD, 5'h18};
      endcase
      filter_rolloff_sel_o <= rolloff_r;
      atten_step_mode_o <= att_mode_r;
      output_phase_invert_o <= phase_r;
      atten_left_o <= att_cur_l_r;
      atten_right_o <= att_cur_r_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: status words, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      avs_readdata_o <= 32'h0;
    else if (avs_read_i && !rd_busy_r)
    begin
      case (idx)
        afc_pkg::IDX_ATTL: avs_readdata_o <= {24'h0, att_cur_l_r};
        afc_pkg::IDX_ATTR: avs_readdata_o <= {24'h0, att_cur_r_r};
        afc_pkg::IDX_STATUS: avs_readdata_o <= {29'h0, zcomb_r, zr_s2_r, zl_s2_r};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_phase_follow;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wr_ok && word_idx(avs_address_i) == afc_pkg::IDX_PHASE) |-> ##2
        output_phase_invert_o == $past(wdata[afc_pkg::PHASE_BIT], 2);
  endproperty
  a_phase_follow: assert property (p_phase_follow) else $error("phase bit not applied");

  property p_zero_pol;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (!zcomb_r && $stable(zpol_r)) |=> left_zero_flag_o == ($past(zl_s2_r) ^ $past(zpol_r));
  endproperty
  a_zero_pol: assert property (p_zero_pol) else $error("left zero flag polarity wrong");

  property p_comb_idle;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      zcomb_r |=> left_zero_flag_o == $past(zpol_r);
  endproperty
  a_comb_idle: assert property (p_comb_idle) else $error("unassigned flag not idle");

  property p_rate_gate;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !deemph_en_r |=> deemph_rate_sel_o == afc_pkg::RATE_44K1 && !deemph_enable_o;
  endproperty
  a_rate_gate: assert property (p_rate_gate) else $error("rate shown while disabled");

  property p_rate_legal;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      deemph_rate_r != 2'h3;
  endproperty
  a_rate_legal: assert property (p_rate_legal) else $error("reserved rate stored");

  property p_fmt_rj16;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      fmt_r == afc_pkg::FMT_RJ16 |=> word_bits_o == 5'h10 && serial_frame_o == afc_pkg::AFC_FRAME_RJ;
  endproperty
  a_fmt_rj16: assert property (p_fmt_rj16) else $error("16-bit right-justified wrong");

  property p_fmt_legal;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      fmt_r < 3'h6 ##1 1'b1 |-> serial_frame_o != afc_pkg::AFC_FRAME_BAD;
  endproperty
  a_fmt_legal: assert property (p_fmt_legal) else $error("reserved format shown");

  property p_att_one_step;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !step_en |=> $stable(att_cur_l_r);
  endproperty
  a_att_one_step: assert property (p_att_one_step) else $error("attenuator moved off tick");

  property p_rolloff;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(rolloff_r) |=> filter_rolloff_sel_o == $past(rolloff_r);
  endproperty
  a_rolloff: assert property (p_rolloff) else $error("rolloff not applied");

  property p_mode;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(att_mode_r) |=> atten_step_mode_o == $past(att_mode_r);
  endproperty
  a_mode: assert property (p_mode) else $error("step mode not applied");
endmodule // afc_regs

// *** tb/afc_host_model.sv ***
// Host model: Avalon-MM master that writes and reads the format control bank
module afc_host_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  output logic [7:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rdata;
  // Idle bus at time zero
  initial
  begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle, held until waitrequest is seen low
  task automatic xfer(input logic rd, input logic [6:0] idx, input logic [15:0] cw,
    input logic [3:0] be);
    logic done;
    done = 1'b0;
    @(posedge ref_clk_i);
    avs_address_o <= {idx[5:0], 2'h0};
    avs_writedata_o <= {16'hA5A5, cw}; // Upper half is don't care
    avs_byteenable_o <= be;
    avs_read_o <= rd;
    avs_write_o <= !rd;
    // Request held until the rising edge that sees waitrequest low
    while (!done)
    begin
      @(posedge ref_clk_i);
      done = (avs_waitrequest_i === 1'b0);
    end
    rdata = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // Released address and data lines carry no stale value
    avs_address_o <= ~avs_address_o;
    avs_writedata_o <= ~avs_writedata_o;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] data,
    input logic [15:0] flip = 16'h0, input logic [3:0] be = 4'hF);
    xfer(1'b0, idx, {1'b0, idx, data} ^ flip, be);
  endtask
  // Register read, data returned in q
  task automatic rd(input logic [6:0] idx, output logic [31:0] q);
    xfer(1'b1, idx, 16'h0, 4'hF);
    q = rdata;
  endtask
endmodule // afc_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the format control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPS = 2;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic zero_l = 1'b0;
  logic zero_r = 1'b0;
  logic [7:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_s;
  logic de_en;
  logic [1:0] de_rate;
  logic [1:0] frame;
  logic [4:0] wbits;
  logic roll;
  logic smode;
  logic inv;
  logic [7:0] att_l;
  logic [7:0] att_r;
  logic zf_l;
  logic zf_r;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  afc_regs #(.CLKS_PER_SAMPLE(CPS)) i_afc_regs (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
    .zero_left_i(zero_l), .zero_right_i(zero_r), .deemph_enable_o(de_en),
    .deemph_rate_sel_o(de_rate), .serial_frame_o(frame), .word_bits_o(wbits),
    .filter_rolloff_sel_o(roll), .atten_step_mode_o(smode), .output_phase_invert_o(inv),
    .atten_left_o(att_l), .atten_right_o(att_r), .left_zero_flag_o(zf_l),
    .right_zero_flag_o(zf_r));
  afc_host_model i_afc_host_model (.ref_clk_i(ref_clk), .avs_readdata_i(rdata),
    .avs_waitrequest_i(wait_s), .avs_address_o(addr), .avs_read_o(rd_s),
    .avs_write_o(wr_s), .avs_writedata_o(wdata), .avs_byteenable_o(be));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Let register updates land
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values at the outputs
  task automatic t_reset();
    chk("de_en", de_en, 1'b0);
    chk("de_rate", de_rate, 2'h0);
    chk("frame", frame, 2'h3);
    chk("roll", roll, 1'b0);
    chk("smode", smode, 1'b0);
    chk("inv", inv, 1'b0);
    chk("att", {att_l, att_r}, 16'hFFFF);
    chk("zflags", {zf_l, zf_r}, 2'h0);
    $display("test reset done");
  endtask
  // Every legal format code, rolloff toggled alongside
  task automatic t_format();
    logic [1:0] fr [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    logic [4:0] wb [4] = '{5'h18, 5'h14, 5'h12, 5'h10};
    logic [2:0] i;
    for (int k = 0; k < 6; k++)
    begin
      i = k[2:0];
      i_afc_host_model.wr(afc_pkg::IDX_FORMAT, {2'h0, i[0], 2'h0, i});
      settle(2);
      chk("frame", frame, fr[k]);
      if (k < 4)
        chk("wbits", wbits, wb[k]);
      chk("roll", roll, i[0]);
    end
    i_afc_host_model.wr(afc_pkg::IDX_FORMAT, 8'h06);
    settle(2);
    chk("fmt_rsv", {frame, wbits}, 7'h78);
    $display("test format done");
  endtask
  // Rate ignored while disabled, then each legal rate enabled
  task automatic t_deemph();
    logic [1:0] r;
    i_afc_host_model.wr(afc_pkg::IDX_DEEMPH, 8'h20);
    settle(2);
    chk("de_off", {de_en, de_rate}, 3'h0);
    for (int k = 1; k < 4; k++)
    begin
      r = 2'(k % 3);
      i_afc_host_model.wr(afc_pkg::IDX_DEEMPH, {1'b0, r, 1'b1, 4'h0});
      settle(2);
      chk("de_on", {de_en, de_rate}, {1'b1, r});
    end
    i_afc_host_model.wr(afc_pkg::IDX_DEEMPH, 8'h70);
    settle(2);
    chk("de_rsv", {de_en, de_rate}, 3'h4);
    $display("test deemph done");
  endtask
  // Phase, zero-flag polarity and combined flag
  task automatic t_zero();
    logic [31:0] q;
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h01);
    @(posedge ref_clk);
    zero_l <= 1'b1;
    settle(4);
    chk("inv", inv, 1'b1);
    chk("zf_pos", {zf_l, zf_r}, 2'h2);
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h02);
    settle(2);
    chk("zf_neg", {inv, zf_l, zf_r}, 3'h1);
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h04);
    settle(2);
    chk("zf_one", {zf_l, zf_r}, 2'h0);
    @(posedge ref_clk);
    zero_r <= 1'b1;
    settle(4);
    chk("zf_both", {zf_l, zf_r}, 2'h1);
    i_afc_host_model.rd(afc_pkg::IDX_STATUS, q);
    chk("status", q, 32'h7);
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h06);
    settle(2);
    chk("zf_both_neg", {zf_l, zf_r}, 2'h2);
    $display("test zero done");
  endtask
  // Bad top bit, missing byte lane, write-only and unmapped reads
  task automatic t_refuse();
    logic [31:0] q;
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h01);
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h00, 16'h8000);
    i_afc_host_model.wr(afc_pkg::IDX_PHASE, 8'h00, 16'h0, 4'hE);
    settle(2);
    chk("refused", inv, 1'b1);
    i_afc_host_model.rd(afc_pkg::IDX_PHASE, q);
    chk("rd_wo", q, 32'h0);
    i_afc_host_model.rd(7'h20, q);
    chk("rd_unmapped", q, 32'h0);
    $display("test refuse done");
  endtask
  // Wide mode, two steps of one code each, spaced eight samples
  task automatic t_atten();
    int t [2];
    int k;
    logic [7:0] prev;
    logic [31:0] q;
    k = 0;
    prev = 8'hFF;
    i_afc_host_model.wr(afc_pkg::IDX_ATTMODE, 8'h01);
    i_afc_host_model.wr(afc_pkg::IDX_ATTL, 8'hFD);
    for (int n = 0; n < 80; n++)
    begin
      settle(1);
      if (att_l !== prev && k < 2)
      begin
        chk("att_step", prev - att_l, 32'h1);
        t[k] = n;
        k++;
        prev = att_l;
      end
    end
    chk("att_count", k, 32'h2);
    chk("att_gap", t[1] - t[0], 8 * CPS);
    chk("att_end", {att_l, att_r, smode}, 17'h1FBFF);
    i_afc_host_model.rd(afc_pkg::IDX_ATTL, q);
    chk("rd_att", q, 32'hFD);
    $display("test atten done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] timeout expected done seen hang");
      end_sim();
    end
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    settle(1);
    t_reset();
    t_format();
    t_deemph();
    t_zero();
    t_refuse();
    t_atten();
    end_sim();
  end
endmodule // tb_top
